// *** rtl/pmr_pkg.sv ***
// constants of the pack monitor result register bank
// assumes a single core clock and an i2c host reaching the bank
package pmr_pkg;
  // register byte addresses
  localparam logic [7:0] NV_AREA_END    = 8'h4c;
  localparam logic [7:0] REG_STATUS     = 8'h84;
  localparam logic [7:0] REG_FET_CTRL   = 8'h86;
  localparam logic [7:0] REG_CONTROL    = 8'h88;
  localparam logic [7:0] REG_THERM_ONE  = 8'ha2;
  localparam logic [7:0] REG_THERM_TWO  = 8'ha4;
  localparam logic [7:0] REG_PACK_VOLT  = 8'ha6;
  localparam logic [7:0] REG_REG_VOLT   = 8'ha8;
  localparam logic [7:0] REG_RAW_ADC    = 8'haa;
  localparam logic [7:0] RSV_A_LO       = 8'h4c;
  localparam logic [7:0] RSV_A_HI       = 8'h4f;
  localparam logic [7:0] RSV_B_LO       = 8'h58;
  localparam logic [7:0] RSV_B_HI       = 8'h7f;
  localparam logic [7:0] RSV_C_LO       = 8'hac;
  // field positions
  localparam int        BIT_IN_SLEEP   = 0;
  localparam int        BIT_FET_CHG    = 0;
  localparam int        BIT_FET_DSG    = 1;
  localparam int        BIT_FET_HOST   = 2;
  localparam int        BIT_SLEEP_CMD  = 0;
  localparam int        BIT_NV_ENABLE  = 1;
  localparam logic [7:0] FET_WR_MASK   = 8'h07;
  // sizes and reset values
  localparam int        NV_DEPTH       = 76;
  localparam int        RESULT_W       = 12;
  localparam int        RAW_W          = 14;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] PTR_RESET     = 8'h00;
  localparam logic [6:0] DEV_ADDR_DEF  = 7'h28; // arbitrary value
  typedef enum logic [2:0] {
    PMR_IDLE, PMR_ADDR, PMR_ACK, PMR_WDATA, PMR_RDATA, PMR_RACK
  } pmr_state_t;
endpackage

// *** rtl/pmr_top.sv ***
// pack monitor result register bank with its i2c slave port
// assumes scl/sda and monitor pins are asynchronous; protection and
// measurement inputs come from logic on the core clock
`timescale 1ns/100ps
module pmr_top #(
  parameter logic [6:0] DEV_ADDR = pmr_pkg::DEV_ADDR_DEF
) (
  input  wire logic                        CORE_CLK_I,
  input  wire logic                        RESET_N_I,
  input  wire logic                        SCL_I,
  input  wire logic                        SDA_I,
  output logic                             SDA_O,
  output logic                             SDA_OE_O,
  input  wire logic                        CHARGER_MON_I,
  input  wire logic                        LOAD_MON_I,
  input  wire logic                        SLEEP_ENTER_I,
  input  wire logic                        AUTO_CHG_ON_I,
  input  wire logic                        AUTO_DSG_ON_I,
  input  wire logic                        RESULT_LOAD_I,
  input  wire logic [pmr_pkg::RESULT_W-1:0] THERM_ONE_I,
  input  wire logic [pmr_pkg::RESULT_W-1:0] THERM_TWO_I,
  input  wire logic [pmr_pkg::RESULT_W-1:0] PACK_VOLT_I,
  input  wire logic [pmr_pkg::RESULT_W-1:0] REG_VOLT_I,
  input  wire logic [pmr_pkg::RAW_W-1:0]    RAW_ADC_I,
  output logic                             CHG_DRIVE_O,
  output logic                             DSG_DRIVE_O,
  output logic                             IN_SLEEP_O,
  output logic                             NV_ENABLE_O
);

  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // pin synchronisers: [0] first stage, [1] second stage, [2] previous of [1]
  logic [2:0] scl_r;
  logic [2:0] sda_r;
  logic [2:0] chm_r;
  logic [2:0] ldm_r;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      scl_r <= 3'h7;
      sda_r <= 3'h7;
      chm_r <= 3'h0;
      ldm_r <= 3'h0;
    end else begin
      scl_r <= {scl_r[1:0], SCL_I};
      sda_r <= {sda_r[1:0], SDA_I};
      chm_r <= {chm_r[1:0], CHARGER_MON_I};
      ldm_r <= {ldm_r[1:0], LOAD_MON_I};
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_rise  = scl_r[1] & ~scl_r[2];
  assign scl_fall  = ~scl_r[1] & scl_r[2];
  assign bus_start = scl_r[1] & scl_r[2] & ~sda_r[1] & sda_r[2];
  assign bus_stop  = scl_r[1] & scl_r[2] & sda_r[1] & ~sda_r[2];

  // result capture
  logic [pmr_pkg::RESULT_W-1:0] therm_one_r;
  logic [pmr_pkg::RESULT_W-1:0] therm_two_r;
  logic [pmr_pkg::RESULT_W-1:0] pack_volt_r;
  logic [pmr_pkg::RESULT_W-1:0] reg_volt_r;
  logic [pmr_pkg::RAW_W-1:0]    raw_adc_r;

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      therm_one_r <= '0;
      therm_two_r <= '0;
      pack_volt_r <= '0;
      reg_volt_r  <= '0;
      raw_adc_r   <= '0;
    end else if (RESULT_LOAD_I) begin
      therm_one_r <= THERM_ONE_I;
      therm_two_r <= THERM_TWO_I;
      pack_volt_r <= PACK_VOLT_I;
      reg_volt_r  <= REG_VOLT_I;
      raw_adc_r   <= RAW_ADC_I;
    end
  end

  // register and slave state
  pmr_pkg::pmr_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic       ptr_phase_r, ptr_phase_nxt;
  logic       rw_r, rw_nxt;
  logic       sda_oe_r, sda_oe_nxt;
  logic [2:0] fet_host_r, fet_host_nxt;
  logic       nv_en_r, nv_en_nxt;
  logic       sleep_r, sleep_nxt;
  logic       chg_r, chg_nxt;
  logic       dsg_r, dsg_nxt;
  logic       sleep_cmd;
  logic       mem_we;
  logic [7:0] mem_wdata;
  logic [7:0] rd_byte;
  logic [7:0] shadow_mem [0:pmr_pkg::NV_DEPTH-1];
  logic [7:0] nvm_mem    [0:pmr_pkg::NV_DEPTH-1];

  // byte read at the pointer
  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [15:0] w;
    w = 16'h0000;
    read_byte = 8'h00;
    case ({a[7:1], 1'b0})
      pmr_pkg::REG_THERM_ONE: w = {4'h0, therm_one_r};
      pmr_pkg::REG_THERM_TWO: w = {4'h0, therm_two_r};
      pmr_pkg::REG_PACK_VOLT: w = {4'h0, pack_volt_r};
      pmr_pkg::REG_REG_VOLT:  w = {4'h0, reg_volt_r};
      pmr_pkg::REG_RAW_ADC:   w = {2'h0, raw_adc_r};
      default:                w = 16'h0000;
    endcase
    if (a >= pmr_pkg::REG_THERM_ONE && a < pmr_pkg::RSV_C_LO) begin
      read_byte = a[0] ? w[15:8] : w[7:0];
    end else if (a < pmr_pkg::NV_AREA_END) begin
      read_byte = nv_en_r ? nvm_mem[a[6:0]] : shadow_mem[a[6:0]];
    end else if (a == pmr_pkg::REG_STATUS) begin
      read_byte[pmr_pkg::BIT_IN_SLEEP] = sleep_r;
    end else if (a == pmr_pkg::REG_FET_CTRL) begin
      read_byte[pmr_pkg::BIT_FET_CHG]  = chg_r;
      read_byte[pmr_pkg::BIT_FET_DSG]  = dsg_r;
      read_byte[pmr_pkg::BIT_FET_HOST] = fet_host_r[pmr_pkg::BIT_FET_HOST];
    end else if (a == pmr_pkg::REG_CONTROL) begin
      read_byte[pmr_pkg::BIT_NV_ENABLE] = nv_en_r;
    end
  endfunction

  always_comb begin
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    shift_nxt     = shift_r;
    ptr_nxt       = ptr_r;
    ptr_phase_nxt = ptr_phase_r;
    rw_nxt        = rw_r;
    sda_oe_nxt    = sda_oe_r;
    fet_host_nxt  = fet_host_r;
    nv_en_nxt     = nv_en_r;
    sleep_cmd     = 1'b0;
    mem_we        = 1'b0;
    mem_wdata     = shift_r;
    rd_byte       = read_byte(ptr_r);
    if (bus_stop) begin
      state_nxt  = pmr_pkg::PMR_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (bus_start) begin
      state_nxt     = pmr_pkg::PMR_ADDR;
      cnt_nxt       = 4'h0;
      ptr_phase_nxt = 1'b1;
      sda_oe_nxt    = 1'b0;
    end else begin
      case (state_r)
        pmr_pkg::PMR_IDLE: begin
          sda_oe_nxt = 1'b0;
        end
        pmr_pkg::PMR_ADDR, pmr_pkg::PMR_WDATA: begin
          if (scl_rise && cnt_r != pmr_pkg::BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_r[1]};
            cnt_nxt   = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == pmr_pkg::BITS_PER_BYTE) begin
            cnt_nxt = 4'h0;
            if (state_r == pmr_pkg::PMR_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                rw_nxt     = shift_r[0];
                sda_oe_nxt = 1'b1;
                state_nxt  = pmr_pkg::PMR_ACK;
              end else begin
                state_nxt = pmr_pkg::PMR_IDLE;
              end
            end else begin
              sda_oe_nxt = 1'b1;
              state_nxt  = pmr_pkg::PMR_ACK;
              if (ptr_phase_r) begin
                ptr_nxt       = shift_r;
                ptr_phase_nxt = 1'b0;
              end else begin
                ptr_nxt = ptr_r + 8'h01;
                if (ptr_r < pmr_pkg::NV_AREA_END) begin
                  mem_we = 1'b1;
                end else if (ptr_r == pmr_pkg::REG_FET_CTRL) begin
                  fet_host_nxt = shift_r[2:0];
                end else if (ptr_r == pmr_pkg::REG_CONTROL) begin
                  sleep_cmd = shift_r[pmr_pkg::BIT_SLEEP_CMD];
                  nv_en_nxt = shift_r[pmr_pkg::BIT_NV_ENABLE];
                end
                // reserved and read-only addresses drop the byte
              end
            end
          end
        end
        pmr_pkg::PMR_ACK: begin
          if (scl_fall) begin
            cnt_nxt = 4'h0;
            if (rw_r) begin
              shift_nxt  = rd_byte;
              sda_oe_nxt = ~rd_byte[7];
              state_nxt  = pmr_pkg::PMR_RDATA;
            end else begin
              sda_oe_nxt = 1'b0;
              state_nxt  = pmr_pkg::PMR_WDATA;
            end
          end
        end
        pmr_pkg::PMR_RDATA: begin
          if (scl_fall) begin
            cnt_nxt   = cnt_r + 4'h1;
            shift_nxt = {shift_r[6:0], 1'b0};
            if (cnt_r == pmr_pkg::BITS_PER_BYTE - 4'h1) begin
              sda_oe_nxt = 1'b0;
              ptr_nxt    = ptr_r + 8'h01;
              state_nxt  = pmr_pkg::PMR_RACK;
            end else begin
              sda_oe_nxt = ~shift_r[6];
            end
          end
        end
        pmr_pkg::PMR_RACK: begin
          if (scl_rise && sda_r[1]) begin
            state_nxt = pmr_pkg::PMR_IDLE;
          end else if (scl_fall) begin
            cnt_nxt    = 4'h0;
            shift_nxt  = rd_byte;
            sda_oe_nxt = ~rd_byte[7];
            state_nxt  = pmr_pkg::PMR_RDATA;
          end
        end
        default: begin
          state_nxt = pmr_pkg::PMR_IDLE;
        end
      endcase
    end
  end

  // sleep status and fet drives
  always_comb begin
    sleep_nxt = sleep_r;
    if (SLEEP_ENTER_I || sleep_cmd) begin
      sleep_nxt = 1'b1;
    end else if ((chm_r[1] & ~chm_r[2]) || (~ldm_r[1] & ldm_r[2])) begin
      sleep_nxt = 1'b0;
    end
    if (fet_host_r[pmr_pkg::BIT_FET_HOST]) begin
      chg_nxt = fet_host_r[pmr_pkg::BIT_FET_CHG];
      dsg_nxt = fet_host_r[pmr_pkg::BIT_FET_DSG];
    end else begin
      chg_nxt = AUTO_CHG_ON_I;
      dsg_nxt = AUTO_DSG_ON_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= pmr_pkg::PMR_IDLE;
      cnt_r       <= 4'h0;
      shift_r     <= 8'h00;
      ptr_r       <= pmr_pkg::PTR_RESET;
      ptr_phase_r <= 1'b1;
      rw_r        <= 1'b0;
      sda_oe_r    <= 1'b0;
      fet_host_r  <= 3'h0;
      nv_en_r     <= 1'b0;
      sleep_r     <= 1'b0;
      chg_r       <= 1'b0;
      dsg_r       <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      shift_r     <= shift_nxt;
      ptr_r       <= ptr_nxt;
      ptr_phase_r <= ptr_phase_nxt;
      rw_r        <= rw_nxt;
      sda_oe_r    <= sda_oe_nxt;
      fet_host_r  <= fet_host_nxt;
      nv_en_r     <= nv_en_nxt;
      sleep_r     <= sleep_nxt;
      chg_r       <= chg_nxt;
      dsg_r       <= dsg_nxt;
    end
  end

  // shadow and nonvolatile arrays
  always_ff @(posedge CORE_CLK_I) begin
    if (mem_we && !nv_en_r) begin
      shadow_mem[ptr_r[6:0]] <= mem_wdata;
    end
    if (mem_we && nv_en_r) begin
      nvm_mem[ptr_r[6:0]] <= mem_wdata;
    end
  end

  assign SDA_O       = 1'b0;
  assign SDA_OE_O    = sda_oe_r;
  assign CHG_DRIVE_O = chg_r;
  assign DSG_DRIVE_O = dsg_r;
  assign IN_SLEEP_O  = sleep_r;
  assign NV_ENABLE_O = nv_en_r;

endmodule

// *** sim/pmr_host_model.sv ***
// i2c host model driving scl and sda of the result register bank
// assumes a pull-up on sda and that this model is the only scl driver
`timescale 1ns/100ps
module pmr_host_model #(
  parameter logic [6:0] DEV = 7'h28
) (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // one bus phase of ten core clocks
  task automatic put(input logic c, d);
    scl_o <= c;
    sda_o <= d;
    repeat (10) @(posedge clk_i);
  endtask
  task automatic start;
    put(1'b0, sda_o);
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
  endtask
  task automatic stop;
    put(1'b0, sda_o);
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask
  // eight bits and the acknowledge, msb first
  task automatic byt(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      put(1'b0, sda_o);
      put(1'b0, d[i]);
      put(1'b1, d[i]);
      q[i] = sda_i;
    end
  endtask
  // callers keep reserved bits zero and stay off reserved addresses
  task automatic wreg(input logic [7:0] a, d, output logic ok);
    logic [8:0] q0, q1, q2;
    start;
    byt({DEV, 2'b01}, q0);
    byt({a, 1'b1}, q1);
    byt({d, 1'b1}, q2);
    stop;
    ok = !(q0[0] | q1[0] | q2[0]);
  endtask
  // callers mask reserved bits of the returned word
  task automatic rreg(input logic [7:0] a, output logic [15:0] v);
    logic [8:0] q0, q1;
    start;
    byt({DEV, 2'b01}, q0);
    byt({a, 1'b1}, q1);
    start;
    byt({DEV, 2'b11}, q0);
    byt(9'h1fe, q0);
    byt(9'h1ff, q1);
    stop;
    v = {q1[8:1], q0[8:1]};
  endtask
endmodule

// *** sim/pmr_top_asserts.sv ***
// port checks of the result register bank
// assumes binding to pmr_top and visibility of its ports only
`timescale 1ns/100ps
module pmr_top_asserts (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic SCL_I,
  input wire logic SDA_OE_O,
  input wire logic CHARGER_MON_I,
  input wire logic LOAD_MON_I,
  input wire logic SLEEP_ENTER_I,
  input wire logic AUTO_CHG_ON_I,
  input wire logic AUTO_DSG_ON_I,
  input wire logic CHG_DRIVE_O,
  input wire logic DSG_DRIVE_O,
  input wire logic IN_SLEEP_O,
  input wire logic NV_ENABLE_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  sleep_set_a : assert property (SLEEP_ENTER_I |=> IN_SLEEP_O)
    else $error("sleep status not set");
  sleep_cause_a : assert property ($rose(IN_SLEEP_O) |-> $past(SLEEP_ENTER_I) || !SCL_I)
    else $error("sleep status set without cause");
  chg_clear_a : assert property ($rose(CHARGER_MON_I) && !SLEEP_ENTER_I |-> ##[1:6] !IN_SLEEP_O)
    else $error("charger rise did not clear sleep");
  load_clear_a : assert property ($fell(LOAD_MON_I) && !SLEEP_ENTER_I |-> ##[1:6] !IN_SLEEP_O)
    else $error("load fall did not clear sleep");
  chg_follow_a : assert property ($changed(CHG_DRIVE_O) |-> CHG_DRIVE_O == $past(AUTO_CHG_ON_I) || !SCL_I)
    else $error("charge drive changed without cause");
  dsg_follow_a : assert property ($changed(DSG_DRIVE_O) |-> DSG_DRIVE_O == $past(AUTO_DSG_ON_I) || !SCL_I)
    else $error("discharge drive changed without cause");
  nv_write_a : assert property ($changed(NV_ENABLE_O) |-> !SCL_I)
    else $error("nonvolatile enable changed outside a write");
  sda_hold_a : assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
    else $error("sda changed while scl high");
endmodule

// *** sim/pmr_top_tb_top.sv ***
// self-checking bench of the result register bank
// assumes the host model as the only i2c master and a pull-up on sda
`timescale 1ns/100ps
module pmr_top_tb_top;
  logic        clk, rst_n, chg_mon, ld_mon, slp, a_chg, a_dsg, ld, ok;
  logic [11:0] t1, t2, pv, rv;
  logic [13:0] raw;
  logic [15:0] v;
  wire logic   scl, h_sda, oe, sda, chg, dsg, slp_o, nv, sdo;
  int          err_count, n_tests;
  assign sda = oe ? (h_sda & sdo) : h_sda;
  pmr_top u_dut (.CORE_CLK_I(clk), .RESET_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sdo), .SDA_OE_O(oe),
    .CHARGER_MON_I(chg_mon), .LOAD_MON_I(ld_mon), .SLEEP_ENTER_I(slp), .AUTO_CHG_ON_I(a_chg),
    .AUTO_DSG_ON_I(a_dsg), .RESULT_LOAD_I(ld), .THERM_ONE_I(t1), .THERM_TWO_I(t2), .PACK_VOLT_I(pv),
    .REG_VOLT_I(rv), .RAW_ADC_I(raw), .CHG_DRIVE_O(chg), .DSG_DRIVE_O(dsg), .IN_SLEEP_O(slp_o),
    .NV_ENABLE_O(nv));
  pmr_host_model u_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));
  task automatic chk(input string n, input logic [15:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic w(input logic [7:0] a, d);
    u_host.wreg(a, d, ok);
    chk("write ack", 16'h0001, {15'h0, ok});
  endtask
  task automatic r(input logic [7:0] a, input logic [15:0] e, m);
    u_host.rreg(a, v);
    chk($sformatf("read %h", a), e, v & m);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    end_of_test;
  end
  initial begin
    {rst_n, chg_mon, ld_mon, slp, a_chg, a_dsg, ld} = 7'b0010000;
    {t1, t2, pv, rv, raw} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(6);
    chk("sleep at power-up", 16'h0000, {15'h0, slp_o});
    t1 <= 12'habc;
    t2 <= 12'h123;
    pv <= 12'hfff;
    rv <= 12'h800;
    raw <= 14'h2001;
    ld <= 1'b1;
    @(posedge clk) ld <= 1'b0;
    r(8'ha2, 16'h0abc, 16'hffff);
    r(8'ha4, 16'h0123, 16'hffff);
    r(8'ha6, 16'h0fff, 16'hffff);
    r(8'ha8, 16'h0800, 16'hffff);
    r(8'haa, 16'h2001, 16'hffff);
    w(8'ha2, 8'h55);
    r(8'ha2, 16'h0abc, 16'hffff);
    r(8'hac, 16'h0000, 16'hffff);
    w(8'h88, 8'h00);
    chk("sleep after zero write", 16'h0000, {15'h0, slp_o});
    @(posedge clk) slp <= 1'b1;
    @(posedge clk) slp <= 1'b0;
    cyc(2);
    chk("sleep entered", 16'h0001, {15'h0, slp_o});
    r(8'h84, 16'h0001, 16'h00ff);
    chg_mon <= 1'b1;
    cyc(8);
    chk("charger clears sleep", 16'h0000, {15'h0, slp_o});
    w(8'h88, 8'h01);
    chk("sleep by command", 16'h0001, {15'h0, slp_o});
    r(8'h88, 16'h0000, 16'h0001);
    ld_mon <= 1'b0;
    cyc(8);
    chk("load clears sleep", 16'h0000, {15'h0, slp_o});
    a_chg <= 1'b1;
    cyc(3);
    chk("auto fets", 16'h0001, {14'h0, dsg, chg});
    r(8'h86, 16'h0001, 16'h00ff);
    w(8'h86, 8'h06);
    chk("host fets", 16'h0002, {14'h0, dsg, chg});
    r(8'h86, 16'h0006, 16'h00ff);
    w(8'h86, 8'h00);
    {a_chg, a_dsg} <= 2'b01;
    cyc(3);
    chk("auto fets again", 16'h0002, {14'h0, dsg, chg});
    w(8'h10, 8'h3c);
    w(8'h88, 8'h02);
    chk("nv enable", 16'h0001, {15'h0, nv});
    w(8'h10, 8'hc3);
    r(8'h10, 16'h00c3, 16'h00ff);
    w(8'h88, 8'h00);
    r(8'h10, 16'h003c, 16'h00ff);
    end_of_test;
  end
endmodule
bind pmr_top pmr_top_asserts u_chk (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .SCL_I(SCL_I),
  .SDA_OE_O(SDA_OE_O), .CHARGER_MON_I(CHARGER_MON_I), .LOAD_MON_I(LOAD_MON_I), .SLEEP_ENTER_I(SLEEP_ENTER_I),
  .AUTO_CHG_ON_I(AUTO_CHG_ON_I), .AUTO_DSG_ON_I(AUTO_DSG_ON_I), .CHG_DRIVE_O(CHG_DRIVE_O),
  .DSG_DRIVE_O(DSG_DRIVE_O), .IN_SLEEP_O(IN_SLEEP_O), .NV_ENABLE_O(NV_ENABLE_O));
